// file: rtl/scse_exec.sv
// Notes on behaviour
// - store halfword address is sign-extended displacement plus base.
// - store halfword writes only the low 16 bits of target.
// - odd halfword address raises address error, store suppressed.
// - store halfword reports tlb refill/invalid/modified, bus and address errors.
// - immediate left shift of low word, zero fill, writes destination.
// - variable left shift count is low five bits of source.
// - in 64-bit mode left shifts sign-extend from bit 31, even count zero.
// - left shift result valid for any input operand.
// - signed compare writes one if less, else zero, upper bits clear.
// - compares never raise overflow and stay correct.
// - signed immediate compare uses sign-extended 16-bit immediate.
// - unsigned immediate compare sign-extends then compares unsigned.
// - unsigned register compare writes one if below, else zero.
// - arithmetic right shift replicates sign, result sign-extended in 64-bit mode.
// - arithmetic right shift undefined if bits 63..31 differ.
// - store double right type is seven minus byte, offset by memory order.
// - store double right in 32-bit user/supervisor is reserved instruction.
// - store double right touches only one doubleword, low register bytes.
`timescale 1ns/1ps
`include "scse_defines.svh"
module scse_exec
  import scse_pkg::*;
(
  // clock and reset
  input  wire logic           clock,
  input  wire logic           resetn,
  // issue
  input  wire logic           issue,
  input  wire scse_pkg::scse_op_t op,
  input  wire logic [63:0]    source_gpr,
  input  wire logic [63:0]    target_gpr,
  input  wire logic [15:0]    imm,
  input  wire logic [4:0]     shift_count_field,
  // mode
  input  wire logic           mode64,
  input  wire logic           kernel_mode,
  input  wire logic           memory_order_flag,
  input  wire logic           processor_order_flag,
  input  wire logic           order_flip_flag,
  // translation status for this store
  input  wire logic           tlb_refill,
  input  wire logic           tlb_invalid,
  input  wire logic           tlb_modified,
  input  wire logic           bus_error,
  // writeback
  output logic                wb_valid,
  output logic [63:0]         wb_data,
  // memory store
  output logic                st_valid,
  output logic                st_half,
  output logic [63:0]         st_addr,
  output logic [2:0]          st_type,
  output logic [2:0]          st_offset,
  output logic [63:0]         st_data,
  // exception
  output logic                exc_valid,
  output scse_pkg::scse_exc_t exc_code
);
  import scse_pkg::*;

  typedef struct packed {
    logic        wb_valid;
    logic [63:0] wb_data;
    logic        st_valid;
    logic        st_half;
    logic [63:0] st_addr;
    logic [2:0]  st_type;
    logic [2:0]  st_offset;
    logic [63:0] st_data;
    logic        exc_valid;
    scse_exc_t   exc_code;
  } scse_state_t;

  scse_state_t st_reg;
  scse_state_t st_next;
  scse_mem_if  mem ();
  logic        misaligned;
  logic        alu_writes;
  logic [63:0] alu_result;
  logic        resv;
  logic        is_store;

  // ------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------
  scse_store_unit u_store (
    .go                   (issue),
    .op                   (op),
    .base_val             (source_gpr),
    .disp                 (imm),
    .target_gpr           (target_gpr),
    .mode64               (mode64),
    .memory_order_flag    (memory_order_flag),
    .processor_order_flag (processor_order_flag),
    .order_flip_flag      (order_flip_flag),
    .mem                  (mem),
    .misaligned           (misaligned)
  );

  scse_alu_unit u_alu (
    .op                (op),
    .source_gpr        (source_gpr),
    .target_gpr        (target_gpr),
    .shift_count_field (shift_count_field),
    .imm               (imm),
    .mode64            (mode64),
    .result            (alu_result),
    .writes            (alu_writes)
  );

  // ------------------------------------------------------------
  // result and exception selection
  // ------------------------------------------------------------
  always_comb begin
    st_next  = '0;
    is_store = (op == SCSE_STORE_HALF) || (op == SCSE_STORE_DRIGHT);
    resv     = (op == SCSE_STORE_DRIGHT) && !mode64 && !kernel_mode;
    st_next.exc_code = SCSE_EXC_NONE;
    if (issue) begin
      // priority: decode fault, alignment, translation, then bus
      if (resv) begin
        st_next.exc_valid = 1'b1;
        st_next.exc_code  = SCSE_EXC_RESV;
      end else if (is_store && misaligned) begin
        st_next.exc_valid = 1'b1;
        st_next.exc_code  = SCSE_EXC_ADDR;
      end else if (is_store && tlb_refill) begin
        st_next.exc_valid = 1'b1;
        st_next.exc_code  = SCSE_EXC_TLB_REFILL;
      end else if (is_store && tlb_invalid) begin
        st_next.exc_valid = 1'b1;
        st_next.exc_code  = SCSE_EXC_TLB_INVALID;
      end else if (is_store && tlb_modified) begin
        st_next.exc_valid = 1'b1;
        st_next.exc_code  = SCSE_EXC_TLB_MOD;
      end else if (is_store && bus_error) begin
        st_next.exc_valid = 1'b1;
        st_next.exc_code  = SCSE_EXC_BUS;
      end else if (mem.req) begin
        st_next.st_valid  = 1'b1;
        st_next.st_half   = mem.is_half;
        st_next.st_addr   = mem.vaddr;
        st_next.st_type   = mem.acc_type;
        st_next.st_offset = mem.offset;
        st_next.st_data   = mem.data;
      end else if (alu_writes) begin
        st_next.wb_valid = 1'b1;
        st_next.wb_data  = alu_result;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_valid  = st_reg.wb_valid;
  assign wb_data   = st_reg.wb_data;
  assign st_valid  = st_reg.st_valid;
  assign st_half   = st_reg.st_half;
  assign st_addr   = st_reg.st_addr;
  assign st_type   = st_reg.st_type;
  assign st_offset = st_reg.st_offset;
  assign st_data   = st_reg.st_data;
  assign exc_valid = st_reg.exc_valid;
  assign exc_code  = st_reg.exc_code;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_half_align_err: assert property (issue && op == SCSE_STORE_HALF && (source_gpr[0] ^ imm[0])
    |=> exc_valid && exc_code == SCSE_EXC_ADDR && !st_valid)
    else $error("odd halfword store not trapped");
  a_half_data_low: assert property (st_valid && st_half && !$past(processor_order_flag)
    |-> st_type == 3'h1
    && (st_data >> {st_addr[2:0], 3'h0}) == {48'h0, $past(target_gpr[15:0])})
    else $error("halfword store data wrong");
  a_half_addr_sum: assert property (issue && op == SCSE_STORE_HALF && mode64 && !resv |=> st_addr == $past(source_gpr) + {{48{$past(imm[15])}}, $past(imm)} || exc_valid)
    else $error("halfword address wrong");
  a_shl_sign_ext: assert property (wb_valid && $past(mode64)
    |-> wb_data[63:32] == {32{wb_data[31]}} || wb_data[63:1] == 63'h0)
    else $error("result not sign extended");
  a_mode32_upper: assert property (wb_valid && !$past(mode64) |-> wb_data[63:32] == 32'h0)
    else $error("32-bit result extended");
  a_shl_value: assert property (issue && op == SCSE_SHL_IMM |=> wb_valid && wb_data[31:0] == ($past(target_gpr[31:0]) << $past(shift_count_field)))
    else $error("left shift wrong");
  a_shl_var_cnt: assert property (issue && op == SCSE_SHL_VAR |=> wb_data[31:0] == ($past(target_gpr[31:0]) << $past(source_gpr[4:0])))
    else $error("variable shift count wrong");
  a_slt_signed: assert property (issue && op == SCSE_SLT && mode64 |=> wb_data == (($signed($past(source_gpr)) < $signed($past(target_gpr))) ? 64'h1 : 64'h0))
    else $error("signed compare wrong");
  a_unsigned_less_cmp_op_unsigned: assert property (issue && op == SCSE_UNSIGNED_LESS_CMP_OP && mode64 |=> wb_data == (($past(source_gpr) < $past(target_gpr)) ? 64'h1 : 64'h0))
    else $error("unsigned compare wrong");
  a_cmp_no_exc: assert property (issue && (op == SCSE_SLT || op == SCSE_SIGNED_LESS_IMM_OP || op == SCSE_UNSIGNED_LESS_IMM_OP || op == SCSE_UNSIGNED_LESS_CMP_OP) |=> !exc_valid)
    else $error("compare raised exception");
  a_sdr_resv: assert property (issue && op == SCSE_STORE_DRIGHT && !mode64 && !kernel_mode |=> exc_valid && exc_code == SCSE_EXC_RESV && !st_valid)
    else $error("reserved store not trapped");
  a_sdr_type: assert property (st_valid && !st_half && !$past(processor_order_flag)
    |-> st_type == 3'h7 - st_addr[2:0]
    && st_offset == ($past(memory_order_flag) ? 3'h0
                     : (st_addr[2:0] ^ {3{$past(order_flip_flag)}})))
    else $error("store right type wrong");

  c_half_store: cover property (st_valid && st_half);
  c_sdr_store: cover property (st_valid && !st_half);
  c_addr_err: cover property (exc_valid && exc_code == SCSE_EXC_ADDR);
  c_slt_one: cover property (wb_valid && wb_data == 64'h1);
endmodule : scse_exec

// file: inc/scse_defines.svh
`ifndef SCSE_DEFINES_SVH
`define SCSE_DEFINES_SVH
`define SCSE_XLEN      64
`define SCSE_WLEN      32
`define SCSE_HALF_LSB  0
`define SCSE_DW_MAX    3'h7
`define SCSE_SA_W      5
`define SCSE_IMM_MSB   15
`define SCSE_BE_HALF   8'h03
`define SCSE_ZERO64    64'h0000000000000000
`define SCSE_ONE64     64'h0000000000000001
`endif

// file: inc/scse_pkg.sv
`include "scse_defines.svh"
package scse_pkg;
  typedef enum logic [3:0] {
    SCSE_NOP, SCSE_STORE_HALF, SCSE_STORE_DRIGHT, SCSE_SHL_IMM, SCSE_SHL_VAR,
    SCSE_SRA_IMM, SCSE_SLT, SCSE_UNSIGNED_LESS_CMP_OP, SCSE_SIGNED_LESS_IMM_OP, SCSE_UNSIGNED_LESS_IMM_OP
  } scse_op_t;

  typedef enum logic [2:0] {
    SCSE_EXC_NONE, SCSE_EXC_ADDR, SCSE_EXC_RESV, SCSE_EXC_TLB_REFILL,
    SCSE_EXC_TLB_INVALID, SCSE_EXC_TLB_MOD, SCSE_EXC_BUS
  } scse_exc_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] result;
    logic        wb_en;
  } scse_alu_st_t;
endpackage : scse_pkg

// file: inc/scse_mem_if.sv
`timescale 1ns/1ps
interface scse_mem_if;
  logic        req;
  logic [63:0] vaddr;
  logic [2:0]  acc_type;
  logic [2:0]  offset;
  logic [63:0] data;
  logic        is_half;
  modport src (output req, vaddr, acc_type, offset, data, is_half);
  modport dst (input  req, vaddr, acc_type, offset, data, is_half);
endinterface : scse_mem_if

// file: rtl/scse_store_unit.sv
`timescale 1ns/1ps
`include "scse_defines.svh"
module scse_store_unit
  import scse_pkg::*;
(
  // operation
  input  wire logic           go,
  input  wire scse_pkg::scse_op_t op,
  input  wire logic [63:0]    base_val,
  input  wire logic [15:0]    disp,
  input  wire logic [63:0]    target_gpr,
  input  wire logic           mode64,
  // byte order
  input  wire logic           memory_order_flag,
  input  wire logic           processor_order_flag,
  input  wire logic           order_flip_flag,
  // memory side
  scse_mem_if.src             mem,
  output logic                misaligned
);
  logic [63:0] ea;
  logic [2:0]  byte_sel;
  logic [2:0]  pa_low;
  logic [5:0]  sh;

  always_comb begin
    ea = {{48{disp[`SCSE_IMM_MSB]}}, disp} + base_val;
    if (!mode64) begin
      ea = {{32{ea[31]}}, ea[31:0]};
    end
    byte_sel = ea[2:0] ^ {3{processor_order_flag}};
    // offset follows the lane byte, so a big-endian core mirrors it
    pa_low   = byte_sel ^ {3{order_flip_flag}};
    sh       = {byte_sel, 3'h0};
    mem.req      = go && (op == SCSE_STORE_HALF || op == SCSE_STORE_DRIGHT);
    mem.vaddr    = ea;
    mem.is_half  = (op == SCSE_STORE_HALF);
    misaligned   = (op == SCSE_STORE_HALF) && ea[`SCSE_HALF_LSB];
    if (op == SCSE_STORE_HALF) begin
      byte_sel = ea[2:0] ^ ({2'h0, 1'h0} | {{2{processor_order_flag}}, 1'h0});
      sh       = {byte_sel, 3'h0};
      mem.acc_type = 3'h1;
      mem.offset   = ea[2:0] ^ {{2{order_flip_flag}}, 1'h0};
      mem.data     = {48'h0, target_gpr[15:0]} << sh;
    end else begin
      mem.acc_type = `SCSE_DW_MAX - byte_sel;
      mem.offset   = memory_order_flag ? 3'h0 : pa_low;
      mem.data     = target_gpr << sh;
    end
  end
endmodule : scse_store_unit

// file: rtl/scse_alu_unit.sv
`timescale 1ns/1ps
`include "scse_defines.svh"
module scse_alu_unit
  import scse_pkg::*;
(
  // operands
  input  wire scse_pkg::scse_op_t op,
  input  wire logic [63:0]    source_gpr,
  input  wire logic [63:0]    target_gpr,
  input  wire logic [4:0]     shift_count_field,
  input  wire logic [15:0]    imm,
  input  wire logic           mode64,
  // result
  output logic [63:0]         result,
  output logic                writes
);
  logic [31:0] w;
  logic [4:0]  cnt;
  logic [63:0] imm_x;
  logic [63:0] a;
  logic [63:0] b;

  always_comb begin
    imm_x = {{48{imm[`SCSE_IMM_MSB]}}, imm};
    cnt   = (op == SCSE_SHL_VAR) ? source_gpr[4:0] : shift_count_field;
    a     = mode64 ? source_gpr : {{32{source_gpr[31]}}, source_gpr[31:0]};
    b     = mode64 ? target_gpr : {{32{target_gpr[31]}}, target_gpr[31:0]};
    w     = 32'h0;
    writes = 1'b1;
    unique case (op)
      SCSE_SHL_IMM, SCSE_SHL_VAR: w = target_gpr[31:0] << cnt;
      SCSE_SRA_IMM: w = $signed(target_gpr[31:0]) >>> cnt;
      default: writes = 1'b0;
    endcase
    // compares read the sign directly, not a subtractor, so never overflow
    unique case (op)
      SCSE_SLT:   result = ($signed(a) < $signed(b)) ? `SCSE_ONE64 : `SCSE_ZERO64;
      SCSE_SIGNED_LESS_IMM_OP:  result = ($signed(a) < $signed(imm_x)) ? `SCSE_ONE64 : `SCSE_ZERO64;
      SCSE_UNSIGNED_LESS_IMM_OP: result = (a < imm_x) ? `SCSE_ONE64 : `SCSE_ZERO64;
      SCSE_UNSIGNED_LESS_CMP_OP:  result = (a < b) ? `SCSE_ONE64 : `SCSE_ZERO64;
      default:    result = mode64 ? {{32{w[31]}}, w} : {32'h0, w};
    endcase
    if (op == SCSE_SLT || op == SCSE_SIGNED_LESS_IMM_OP || op == SCSE_UNSIGNED_LESS_IMM_OP || op == SCSE_UNSIGNED_LESS_CMP_OP) begin
      writes = 1'b1;
    end
  end
endmodule : scse_alu_unit

// file: bench/scse_exec_tb.sv
`timescale 1ns/1ps
module scse_exec_tb;
  import scse_pkg::*;
  logic            clock = 0, resetn = 0, issue = 0, mode64 = 1, kernel_mode = 1;
  logic            memory_order_flag = 0, processor_order_flag = 0, order_flip_flag = 0;
  logic            tlb_refill = 0, tlb_invalid = 0, tlb_modified = 0, bus_error = 0;
  scse_op_t        op = SCSE_NOP;
  logic [63:0]     source_gpr = '0, target_gpr = '0;
  logic [15:0]     imm = '0;
  logic [4:0]      shift_count_field = '0;
  logic            wb_valid, st_valid, st_half, exc_valid;
  logic [63:0]     wb_data, st_addr, st_data;
  logic [2:0]      st_type, st_offset;
  scse_exc_t       exc_code;
  int              fail_count = 0, checks = 0;
  always #12.5 clock = ~clock;
  scse_exec dut (.clock(clock), .resetn(resetn), .issue(issue), .op(op),
    .source_gpr(source_gpr), .target_gpr(target_gpr), .imm(imm),
    .shift_count_field(shift_count_field), .mode64(mode64), .kernel_mode(kernel_mode),
    .memory_order_flag(memory_order_flag), .processor_order_flag(processor_order_flag),
    .order_flip_flag(order_flip_flag), .tlb_refill(tlb_refill), .tlb_invalid(tlb_invalid),
    .tlb_modified(tlb_modified), .bus_error(bus_error), .wb_valid(wb_valid),
    .wb_data(wb_data), .st_valid(st_valid), .st_half(st_half), .st_addr(st_addr),
    .st_type(st_type), .st_offset(st_offset), .st_data(st_data),
    .exc_valid(exc_valid), .exc_code(exc_code));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one-cycle issue; outputs stand for the cycle after the taking edge
  task go(input scse_op_t o, input logic [63:0] rs, rt, input logic [15:0] im,
          input logic [4:0] sa);
    @(posedge clock);
    issue <= 1;
    op <= o;
    source_gpr <= rs;
    target_gpr <= rt;
    imm <= im;
    shift_count_field <= sa;
    @(posedge clock);
    issue <= 0;
    #1;
  endtask : go
  task alu(input scse_op_t o, input logic [63:0] rs, rt, input logic [15:0] im,
           input logic [4:0] sa, input logic [63:0] exp, mask);
    go(o, rs, rt, im, sa);
    chk("wb_valid", wb_valid, 1);
    chk("exc_valid", exc_valid, 0);
    chk("wb_data", wb_data & mask, exp);
  endtask : alu
  task end_sim;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_shifts;
    alu(SCSE_SHL_IMM, 0, 64'h1234567880000001, 0, 0, 64'hFFFFFFFF80000001, '1);
    alu(SCSE_SHL_IMM, 0, 64'h000000000F000001, 0, 4, 64'hFFFFFFFFF0000010, '1);
    alu(SCSE_SHL_IMM, 0, 64'h7000000000000001, 0, 31, 64'hFFFFFFFF80000000, '1);
    alu(SCSE_SHL_VAR, 64'hFFFFFFFFFFFFFFE3, 1, 0, 9, 64'h8, '1);
    alu(SCSE_SRA_IMM, 0, 64'hFFFFFFFF80000000, 0, 4, 64'hFFFFFFFFF8000000, '1);
    alu(SCSE_SRA_IMM, 0, 64'hFFFFFFFF80000000, 0, 31, '1, '1);
    alu(SCSE_SRA_IMM, 0, 64'h40000000, 0, 30, 64'h1, '1);
  endtask : t_shifts
  task t_compares;
    alu(SCSE_SLT, '1, 1, 0, 0, 1, '1);
    alu(SCSE_SLT, 64'h7FFFFFFFFFFFFFFF, 64'h8000000000000000, 0, 0, 0, '1);
    alu(SCSE_UNSIGNED_LESS_CMP_OP, 1, '1, 0, 0, 1, '1);
    alu(SCSE_UNSIGNED_LESS_CMP_OP, '1, 1, 0, 0, 0, '1);
    alu(SCSE_SIGNED_LESS_IMM_OP, 64'hFFFFFFFFFFFFFFFE, 0, 16'hFFFF, 0, 1, '1);
    alu(SCSE_SIGNED_LESS_IMM_OP, 0, 0, 16'h8000, 0, 0, '1);
    alu(SCSE_UNSIGNED_LESS_IMM_OP, 1, 0, 16'hFFFF, 0, 1, '1);
    alu(SCSE_UNSIGNED_LESS_IMM_OP, '1, 0, 16'hFFFF, 0, 0, '1);
  endtask : t_compares
  task t_mode32;
    mode64 <= 0;
    kernel_mode <= 0;
    alu(SCSE_SHL_IMM, 0, 64'h3, 0, 30, 64'hC0000000, '1);
    alu(SCSE_SLT, 64'h80000000, 1, 0, 0, 1, '1);
    go(SCSE_STORE_DRIGHT, 64'h2000, 1, 0, 0);
    chk("st_valid", st_valid, 0);
    chk("resv", exc_code, SCSE_EXC_RESV);
    kernel_mode <= 1;
    go(SCSE_STORE_DRIGHT, 64'h2000, 1, 0, 0);
    chk("st_valid", st_valid, 1);
    mode64 <= 1;
  endtask : t_mode32
  task t_store_half;
    scse_exc_t codes[4];
    codes = '{SCSE_EXC_TLB_REFILL, SCSE_EXC_TLB_INVALID, SCSE_EXC_TLB_MOD, SCSE_EXC_BUS};
    go(SCSE_STORE_HALF, 64'h1000, 64'hAAAABBBBCCCC1234, 16'hFFFE, 0);
    chk("st_valid", st_valid, 1);
    chk("st_half", st_half, 1);
    chk("st_addr", st_addr, 64'hFFE);
    chk("st_type", st_type, 1);
    chk("st_data", st_data, 64'h1234000000000000);
    go(SCSE_STORE_HALF, 64'h1000, 1, 16'h0003, 0);
    chk("st_valid", st_valid, 0);
    chk("addr_exc", exc_code, SCSE_EXC_ADDR);
    for (int i = 0; i < 4; i++) begin
      {tlb_refill, tlb_invalid, tlb_modified, bus_error} <= 4'h8 >> i;
      go(SCSE_STORE_HALF, 64'h1000, 1, 0, 0);
      chk("exc_valid", exc_valid, 1);
      chk("st_valid", st_valid, 0);
      chk("exc_code", exc_code, codes[i]);
    end
    {tlb_refill, tlb_invalid, tlb_modified, bus_error} <= 4'h0;
  endtask : t_store_half
  // every start byte under both processor and memory orders
  task t_store_dright;
    logic [2:0] b;
    for (int k = 0; k < 32; k++) begin
      processor_order_flag <= k[4];
      memory_order_flag <= k[3];
      b = k[2:0] ^ {3{k[4]}};
      go(SCSE_STORE_DRIGHT, 64'h2000 + k[2:0], 64'h0807060504030201, 0, 0);
      chk("st_valid", st_valid, 1);
      chk("st_type", st_type, 3'h7 - b);
      chk("st_offset", st_offset, k[3] ? 3'h0 : b);
      chk("st_data", st_data, 64'h0807060504030201 << (8 * b));
    end
    processor_order_flag <= 0;
    memory_order_flag <= 0;
    order_flip_flag <= 1;
    go(SCSE_STORE_DRIGHT, 64'h2003, 1, 0, 0);
    chk("st_offset", st_offset, 3'h4);
    chk("st_type", st_type, 3'h4);
    order_flip_flag <= 0;
  endtask : t_store_dright
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1;
    #1;
    chk("wb_valid", wb_valid, 0);
    chk("st_valid", st_valid, 0);
    t_shifts;
    t_compares;
    t_mode32;
    t_store_half;
    t_store_dright;
    end_sim;
  end
endmodule : scse_exec_tb
